// file: inc/lcgc_map.svh
// Constants of the LED current gain configuration block
`ifndef LCGC_MAP_SVH
`define LCGC_MAP_SVH
`define LCGC_WORD_W      16
`define LCGC_CFG_RESET   8'hFF
`define LCGC_MANT_RESET  6'h3F
`define LCGC_VG_RESET    8'hFE
`define LCGC_CG_RESET    10'h2FA
`define LCGC_BIT_MULT    0
`define LCGC_BIT_BAND    1
`define LCGC_MANT_LO     2
`define LCGC_MANT_HI     7
`define LCGC_MULT_HI     5'h0F
`define LCGC_MULT_LO     5'h05
`endif

// file: inc/lcgc_pkg.sv
// Types of the LED current gain configuration block
package lcgc_pkg;
    typedef enum logic [1:0] {LCGC_IDLE, LCGC_HELD} lcgc_strobe_t;
endpackage : lcgc_pkg

// file: logic/lcgc_core.sv
// LED current gain configuration word and decoder
`timescale 1ns/1ns
`include "lcgc_map.svh"
module lcgc_core
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Mode and shift register contents
    input  wire logic        special_mode,
    input  wire logic [15:0] shift_word,
    // Latch strobe pin
    input  wire logic        latch_strobe,
    // Decoded configuration
    output logic             current_multiplier_sel,
    output logic             high_band_sel,
    output logic [5:0]       gain_mantissa,
    output logic [7:0]       voltage_gain,
    output logic [4:0]       current_mult_ratio,
    output logic [9:0]       current_gain_num,
    output logic [7:0]       config_code
);
    // ------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------
    lcgc_pkg::lcgc_strobe_t st_r;
    lcgc_pkg::lcgc_strobe_t st_nxt;
    logic       strobe_lvl;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic       mult_r;
    logic       mult_nxt;
    logic       band_r;
    logic       band_nxt;
    logic [5:0] mant_r;
    logic [5:0] mant_nxt;
    logic [7:0] vg_r;
    logic [7:0] vg_nxt;
    logic [4:0] ratio_r;
    logic [4:0] ratio_nxt;
    logic [9:0] cg_r;
    logic [9:0] cg_nxt;
    logic       latch_ev;

    // Reverse mantissa so position 2 is weight 32
    function automatic logic [5:0] mant_of(input logic [7:0] c);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 0; i < 6; i++)
            m[5-i] = c[`LCGC_MANT_LO+i];
        return m;
    endfunction : mant_of

    // Voltage gain in 1/256 units: (1+band)*(64+D), 64..127 or 128..254
    function automatic logic [7:0] vg_of(input logic b, input logic [5:0] d);
        logic [7:0] base;
        base = {2'h1, 6'h00} + {2'h0, d};
        return b ? {base[6:0], 1'h0} : base;
    endfunction : vg_of

    // ------------------------------------------------------------
    // Strobe synchroniser and edge detection
    // ------------------------------------------------------------
    lcgc_sync u_strobe_sync
    (
        .clk    (clk),
        .resetn (resetn),
        .pin    (latch_strobe),
        .level  (strobe_lvl)
    );

    // Rising strobe while in special mode is one latch event
    assign latch_ev = special_mode && strobe_lvl && (st_r == lcgc_pkg::LCGC_IDLE);

    // Next values of the configuration and its decode
    always_comb
    begin
        st_nxt    = strobe_lvl ? lcgc_pkg::LCGC_HELD : lcgc_pkg::LCGC_IDLE;
        cfg_nxt   = cfg_r;
        mult_nxt  = mult_r;
        band_nxt  = band_r;
        mant_nxt  = mant_r;
        vg_nxt    = vg_r;
        ratio_nxt = ratio_r;
        cg_nxt    = cg_r;
        if (latch_ev)
        begin
            cfg_nxt   = shift_word[7:0];
            mult_nxt  = shift_word[`LCGC_BIT_MULT];
            band_nxt  = shift_word[`LCGC_BIT_BAND];
            mant_nxt  = mant_of(shift_word[7:0]);
            vg_nxt    = vg_of(shift_word[`LCGC_BIT_BAND], mant_of(shift_word[7:0]));
            ratio_nxt = shift_word[`LCGC_BIT_MULT] ? `LCGC_MULT_HI : `LCGC_MULT_LO;
            // Current gain in 1/768 units: VG*3 or VG; reaches 762, so ten bits
            cg_nxt    = shift_word[`LCGC_BIT_MULT]
                      ? ({2'h0, vg_nxt} + {1'h0, vg_nxt, 1'h0})
                      : {2'h0, vg_nxt};
        end
    end

    // Registers; power-on word is all ones
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_r    <= lcgc_pkg::LCGC_IDLE;
            cfg_r   <= `LCGC_CFG_RESET;
            mult_r  <= 1'h1;
            band_r  <= 1'h1;
            mant_r  <= `LCGC_MANT_RESET;
            vg_r    <= `LCGC_VG_RESET;
            ratio_r <= `LCGC_MULT_HI;
            cg_r    <= `LCGC_CG_RESET;
        end
        else
        begin
            st_r    <= st_nxt;
            cfg_r   <= cfg_nxt;
            mult_r  <= mult_nxt;
            band_r  <= band_nxt;
            mant_r  <= mant_nxt;
            vg_r    <= vg_nxt;
            ratio_r <= ratio_nxt;
            cg_r    <= cg_nxt;
        end
    end

    assign current_multiplier_sel = mult_r;
    assign high_band_sel          = band_r;
    assign gain_mantissa          = mant_r;
    assign voltage_gain           = vg_r;
    assign current_mult_ratio     = ratio_r;
    assign current_gain_num       = cg_r;
    assign config_code            = cfg_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_latch;
        latch_ev;
    endsequence

    property p_latch_copy;
        @(posedge clk) disable iff (!resetn)
        s_latch |=> (cfg_r == $past(shift_word[7:0]));
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("word not latched");

    property p_hold;
        @(posedge clk) disable iff (!resetn)
        !latch_ev |=> $stable(cfg_r) && $stable(mant_r) && $stable(vg_r);
    endproperty
    a_hold: assert property (p_hold) else $error("config changed without latch");

    property p_no_latch_normal;
        @(posedge clk) disable iff (!resetn)
        !special_mode |=> $stable(cfg_r);
    endproperty
    a_no_latch_normal: assert property (p_no_latch_normal) else $error("latched in normal mode");

    property p_mult_bit;
        @(posedge clk) disable iff (!resetn)
        mult_r == cfg_r[0];
    endproperty
    a_mult_bit: assert property (p_mult_bit) else $error("multiplier not bit 0");

    property p_band_bit;
        @(posedge clk) disable iff (!resetn)
        band_r == cfg_r[1];
    endproperty
    a_band_bit: assert property (p_band_bit) else $error("band not bit 1");

    property p_mant_order;
        @(posedge clk) disable iff (!resetn)
        mant_r[5] == cfg_r[2] && mant_r[0] == cfg_r[7];
    endproperty
    a_mant_order: assert property (p_mant_order) else $error("mantissa weight wrong");

    property p_vg_range;
        @(posedge clk) disable iff (!resetn)
        band_r ? (vg_r >= 8'h80 && vg_r <= 8'hFE) : (vg_r >= 8'h40 && vg_r <= 8'h7F);
    endproperty
    a_vg_range: assert property (p_vg_range) else $error("voltage gain out of band");

    property p_vg_value;
        @(posedge clk) disable iff (!resetn)
        vg_r == (band_r ? 8'(({2'h0, mant_r} + 8'h40) << 1) : ({2'h0, mant_r} + 8'h40));
    endproperty
    a_vg_value: assert property (p_vg_value) else $error("voltage gain formula");

    property p_ratio;
        @(posedge clk) disable iff (!resetn)
        ratio_r == (mult_r ? 5'h0F : 5'h05);
    endproperty
    a_ratio: assert property (p_ratio) else $error("multiplier ratio wrong");

    property p_cg;
        @(posedge clk) disable iff (!resetn)
        cg_r == (mult_r ? 10'({2'h0, vg_r} * 10'h003) : {2'h0, vg_r});
    endproperty
    a_cg: assert property (p_cg) else $error("current gain wrong");

    property p_reset_val;
        @(posedge clk)
        !resetn |=> (cfg_r == 8'hFF && cg_r == 10'h2FA);
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("reset value wrong");
endmodule : lcgc_core

// file: logic/lcgc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module lcgc_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Pin in, filtered level out
    input  wire logic pin,
    output logic      level
);
    logic [2:0] stg_r;
    logic [2:0] stg_nxt;
    logic       level_r;
    logic       level_nxt;

    // Next state: shift, take new level when stages two and three agree
    always_comb
    begin
        stg_nxt   = {stg_r[1:0], pin};
        level_nxt = (stg_r[2] == stg_r[1]) ? stg_r[2] : level_r;
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            stg_r   <= 3'h0;
            level_r <= 1'h0;
        end
        else
        begin
            stg_r   <= stg_nxt;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
endmodule : lcgc_sync

// file: test/lcgc_host.sv
// Host model that shifts a word in and strobes it
`timescale 1ns/1ns
module lcgc_host
(
    // Clocks
    input  wire logic   clk,
    input  wire logic   sclk,
    // Serial side towards the core
    output logic        special_mode,
    output logic [15:0] shift_word,
    output logic        latch_strobe
);
    // Idle levels
    initial
    begin
        special_mode = 1'b0;
        shift_word   = 16'h0000;
        latch_strobe = 1'b0;
    end
    // Shift MSB first, then hold the strobe
    task automatic send(input logic [15:0] w, input logic mode, input int hold);
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge sclk);
            @(negedge clk);
            shift_word = {shift_word[14:0], w[i]};
        end
        special_mode = mode;
        @(negedge clk);
        latch_strobe = 1'b1;
        repeat (hold) @(negedge clk);
        latch_strobe = 1'b0;
        repeat (6) @(negedge clk);
        special_mode = 1'b0;
    endtask : send
endmodule : lcgc_host

// file: test/tb_top.sv
// Self-checking bench for the gain configuration core
`timescale 1ns/1ns
module tb_top;
    logic        clk;
    logic        resetn;
    logic        sclk;
    logic        sclk_en;
    logic        special_mode;
    logic        latch_strobe;
    logic [15:0] shift_word;
    logic        mult;
    logic        band;
    logic [5:0]  mant;
    logic [7:0]  vg;
    logic [4:0]  ratio;
    logic [9:0]  cg;
    logic [7:0]  code;
    logic [7:0]  cur;
    int          fail_count;
    int          num_checks;
    logic [15:0] corner [6] = '{16'h0000, 16'h00FC, 16'h0003, 16'hFF01, 16'h00FF, 16'hA55A};

    lcgc_core DUT (.clk(clk), .resetn(resetn), .special_mode(special_mode),
        .shift_word(shift_word), .latch_strobe(latch_strobe),
        .current_multiplier_sel(mult), .high_band_sel(band), .gain_mantissa(mant),
        .voltage_gain(vg), .current_mult_ratio(ratio), .current_gain_num(cg),
        .config_code(code));
    lcgc_host u_host (.clk(clk), .sclk(sclk), .special_mode(special_mode),
        .shift_word(shift_word), .latch_strobe(latch_strobe));

    // Core clock, 50 ns
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Shift clock, 400 ns, off phase, still outside frames
    initial
    begin
        sclk = 1'b0;
        #37;
        forever #200 sclk = sclk_en & ~sclk;
    end
    // Watchdog
    initial
    begin
        #600000;
        fail_count++;
        final_report;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] exp_mant(input logic [7:0] c);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 6; i++) m[i] = c[7-i];
        return m;
    endfunction : exp_mant

    task automatic check_all(input logic [7:0] c);
        logic [15:0] v;
        v = (16'h0001 + c[1]) * (16'h0040 + exp_mant(c));
        chk(mult, c[0]);
        chk(band, c[1]);
        chk(mant, exp_mant(c));
        chk(vg, v);
        chk(ratio, c[0] ? 16'h000F : 16'h0005);
        chk(cg, c[0] ? v * 16'h0003 : v);
        chk(code, c);
    endtask : check_all

    // One framed transfer, then compare
    task automatic run(input logic [15:0] w, input logic mode, input int hold);
        sclk_en = 1'b1;
        u_host.send(w, mode, hold);
        sclk_en = 1'b0;
        if (mode)
            cur = w[7:0];
        repeat (2) @(negedge clk);
        check_all(cur);
    endtask : run

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // Main sequence
    initial
    begin
        fail_count = 0;
        num_checks = 0;
        resetn = 1'b0;
        sclk_en = 1'b0;
        cur = 8'hFF;
        void'($urandom(47941));
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check_all(8'hFF);
        foreach (corner[i]) run(corner[i], 1'b1, 4);
        run(16'h0000, 1'b0, 5);
        repeat (24) run(16'($urandom), 1'($urandom_range(1)), $urandom_range(12, 4));
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        cur = 8'hFF;
        @(negedge clk);
        check_all(cur);
        final_report;
    end
endmodule : tb_top
